// File: hdl/pattern_checker.v
// Bit pattern monitor: predicts each bit from received history.
// Assumes step pulses once per received payload bit.
`timescale 1ns/1ps
`default_nettype none
`include "t1_loop_consts.vh"
module pattern_checker (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Control
    input  wire        restart,
    input  wire        step,
    input  wire        bit_in,
    input  wire        clear_err,
    // Pattern shape
    input  wire        is_prbs,
    input  wire [4:0]  tap_a,
    input  wire [4:0]  tap_b,
    input  wire [4:0]  period,
    // Results
    output reg  [15:0] err_count,
    output reg         err_pulse,
    output wire        synced
);
    reg  [23:0] hist_reg;
    reg  [4:0]  fill_reg;
    wire        expect_bit;
    wire        err;

    assign expect_bit = is_prbs ? (hist_reg[tap_a] ^ hist_reg[tap_b])
                                : hist_reg[period - 5'h01];
    assign synced     = (fill_reg == `HIST_FILL);
    assign err        = step && synced && (bit_in != expect_bit);

    always @(posedge aclk) begin
        if (!aresetn) begin
            hist_reg  <= 24'h00_0000;
            fill_reg  <= 5'h00;
            err_count <= 16'h0000;
            err_pulse <= 1'b0;
        end else begin
            err_pulse <= err;
            if (restart) begin
                fill_reg <= 5'h00;
            end else if (step) begin
                hist_reg <= {hist_reg[22:0], bit_in};
                if (!synced) begin
                    fill_reg <= fill_reg + 5'h01;
                end
            end
            if (clear_err || restart) begin
                err_count <= {15'h0000, err};
            end else if (err && err_count != 16'hFFFF) begin
                err_count <= err_count + 16'h0001;
            end
        end
    end
endmodule // pattern_checker
`default_nettype wire

// File: hdl/pattern_source.v
// Bit pattern generator: shift register or repeating word.
// Assumes step pulses once per payload bit; params stable while sending.
`timescale 1ns/1ps
`default_nettype none
`include "t1_loop_consts.vh"
module pattern_source (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Control
    input  wire        load,
    input  wire        step,
    input  wire        inject,
    // Pattern shape
    input  wire        is_prbs,
    input  wire [4:0]  tap_a,
    input  wire [4:0]  tap_b,
    input  wire [4:0]  period,
    input  wire [23:0] seed,
    // Output bit
    output reg         bit_out
);
    reg  [19:0] lfsr_reg;
    reg  [4:0]  idx_reg;
    reg         inj_reg;
    wire        nb;
    wire [4:0]  pos;

    assign nb  = lfsr_reg[tap_a] ^ lfsr_reg[tap_b];
    assign pos = period - idx_reg - 5'h01;

    always @(posedge aclk) begin
        if (!aresetn) begin
            lfsr_reg <= `LFSR_SEED;
            idx_reg  <= 5'h00;
            inj_reg  <= 1'b0;
            bit_out  <= 1'b0;
        end else if (load) begin
            lfsr_reg <= `LFSR_SEED;
            idx_reg  <= 5'h00;
            inj_reg  <= 1'b0;
        end else if (step) begin
            if (is_prbs) begin
                lfsr_reg <= {lfsr_reg[18:0], nb};
                bit_out  <= nb ^ inj_reg;
            end else begin
                bit_out  <= seed[pos] ^ inj_reg;
            end
            idx_reg <= (idx_reg == period - 5'h01) ? 5'h00 : idx_reg + 5'h01;
            inj_reg <= inject;
        end else if (inject) begin
            inj_reg <= 1'b1;
        end
    end
endmodule // pattern_source
`default_nettype wire

// File: hdl/t1_loop_consts.vh
// Constants for the T1 loopback test control block.
// Assumes inclusion by bare name from the design files.
`ifndef T1_LOOP_CONSTS_VH
`define T1_LOOP_CONSTS_VH

// Clock and times
`define CLK_HZ          50000000
`define CODE_SEND_S     10
`define ELAPSED_UNIT_S  1

// Register byte offsets
`define OFF_CMD         8'h00
`define OFF_STATUS      8'h04
`define OFF_PAT_SEL     8'h08
`define OFF_USER_PAT    8'h0C
`define OFF_ELAPSED     8'h10
`define OFF_ERR_CNT     8'h14
`define OFF_IRQ_STAT    8'h18
`define OFF_IRQ_EN      8'h1C
`define OFF_IRQ_CLR     8'h20

// Command bits
`define CMD_LINE        0
`define CMD_FRAMED      1
`define CMD_TSR         2
`define CMD_STOP_LOOP   3
`define CMD_CODE_UP     4
`define CMD_CODE_DOWN   5
`define CMD_PAT_SEND    6
`define CMD_PAT_STOP    7
`define CMD_MON_START   8
`define CMD_MON_STOP    9
`define CMD_INJECT      10
`define CMD_CLR_ERR     11

// Interrupt bits
`define IRQ_W           3
`define IRQ_REFUSED     0
`define IRQ_CODE_DONE   1
`define IRQ_BIT_ERR     2

// Pattern codes
`define PAT_QRSS        4'h0
`define PAT_ZEROS       4'h1
`define PAT_ONES        4'h2
`define PAT_1IN8        4'h3
`define PAT_3IN24       4'h4
`define PAT_P63         4'h5
`define PAT_P511        4'h6
`define PAT_P2047       4'h7
`define PAT_P15         4'h8
`define PAT_P20         4'h9
`define PAT_USER        4'hA
`define PAT_CODE_UP     4'hB
`define PAT_CODE_DOWN   4'hC

// Fixed pattern words, sent most significant bit first
`define SEED_1IN8       24'h00_0001
`define SEED_3IN24      24'h44_0004
`define SEED_CODE_UP    24'h00_0001
`define SEED_CODE_DOWN  24'h00_0001
`define SEED_ONES       24'h00_0001
`define PER_1IN8        5'h08
`define PER_3IN24       5'h18
`define PER_USER        5'h10
`define PER_CODE_UP     5'h05
`define PER_CODE_DOWN   5'h03
`define PER_ONE         5'h01
`define HIST_FILL       5'h18

// Shift register taps, as bit index of the history
`define TAP_P6A         5'h05
`define TAP_P6B         5'h04
`define TAP_P9A         5'h08
`define TAP_P9B         5'h04
`define TAP_P11A        5'h0A
`define TAP_P11B        5'h08
`define TAP_P15A        5'h0E
`define TAP_P15B        5'h0D
`define TAP_P20A        5'h13
`define TAP_P20B        5'h02
`define TAP_QRSSA       5'h13
`define TAP_QRSSB       5'h10
`define LFSR_SEED       20'hF_FFFF

// Responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// File: hdl/t1_loopback_test_control.v
// T1 interface test control: loop selection, conflict checks, codes, patterns.
// Assumes one bit strobe per T1 bit and framer signals aligned to it.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "t1_loop_consts.vh"
module t1_loopback_test_control #(
    parameter [31:0] SEC_CYCLES  = `CLK_HZ * `ELAPSED_UNIT_S,
    parameter [31:0] CODE_CYCLES = `CLK_HZ * `CODE_SEND_S
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // AXI4-Lite read
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // Interrupt
    output reg         irq,
    // Line side
    input  wire        bit_strobe,
    input  wire        line_rx_bit,
    output reg         line_tx_bit,
    // Framer side
    input  wire        framer_tx_bit,
    input  wire        reframed_bit,
    input  wire        payload_slot,
    output reg         rx_to_framer_bit,
    output reg         framed_loop_en,
    output reg         net_msg_ignore,
    // Tests elsewhere on assigned ports and interfaces
    input  wire        port_pattern_send,
    input  wire        port_v54_ft1_send,
    input  wire        port_data_loop,
    input  wire        linked_if_loop
);
    reg  [7:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         line_reg, framed_reg, tsr_reg, code_reg, code_down_reg;
    reg         pat_send_reg, mon_reg, refused_reg;
    reg  [3:0]  pat_sel_reg;
    reg  [15:0] user_pat_reg;
    reg  [31:0] elapsed_reg, sec_cnt_reg, code_cnt_reg;
    reg  [`IRQ_W-1:0] irq_stat_reg, irq_en_reg;
    reg  [31:0] wmask, cmd, rd_next;
    reg  [3:0]  eff_sel;
    reg         is_prbs;
    reg  [4:0]  tap_a, tap_b, period;
    reg  [23:0] seed;
    reg         refuse_ev, code_done_ev, start_ev, gen_load, mon_load;
    reg         rd_ok;
    wire        wr_go, port_busy, loop_any, gen_bit, gen_step, mon_step;
    wire        err_pulse, mon_synced, tx_raw, slot_over;
    wire [15:0] err_count;

    assign wr_go     = !awready && !wready && !bvalid;
    assign port_busy = port_pattern_send || port_v54_ft1_send || port_data_loop;
    assign loop_any  = line_reg || framed_reg || tsr_reg;
    assign slot_over = (pat_send_reg || code_reg) && payload_slot;
    assign gen_step  = bit_strobe && slot_over;
    assign mon_step  = bit_strobe && mon_reg && payload_slot;

    // Pattern shape select; code sending takes the generator
    always @* begin
        eff_sel = code_reg ? (code_down_reg ? `PAT_CODE_DOWN : `PAT_CODE_UP)
                           : pat_sel_reg;
        is_prbs = 1'b1;
        tap_a   = `TAP_QRSSA;
        tap_b   = `TAP_QRSSB;
        period  = `PER_ONE;
        seed    = 24'h00_0000;
        case (eff_sel)
            `PAT_ZEROS:     is_prbs = 1'b0;
            `PAT_ONES:      begin is_prbs = 1'b0; seed = `SEED_ONES; end
            `PAT_1IN8:      begin is_prbs = 1'b0; period = `PER_1IN8; seed = `SEED_1IN8; end
            `PAT_3IN24:     begin is_prbs = 1'b0; period = `PER_3IN24; seed = `SEED_3IN24; end
            `PAT_P63:       begin tap_a = `TAP_P6A; tap_b = `TAP_P6B; end
            `PAT_P511:      begin tap_a = `TAP_P9A; tap_b = `TAP_P9B; end
            `PAT_P2047:     begin tap_a = `TAP_P11A; tap_b = `TAP_P11B; end
            `PAT_P15:       begin tap_a = `TAP_P15A; tap_b = `TAP_P15B; end
            `PAT_P20:       begin tap_a = `TAP_P20A; tap_b = `TAP_P20B; end
            `PAT_USER:      begin
                is_prbs = 1'b0;
                period  = `PER_USER;
                seed    = {8'h00, user_pat_reg};
            end
            `PAT_CODE_UP:   begin is_prbs = 1'b0; period = `PER_CODE_UP; seed = `SEED_CODE_UP; end
            `PAT_CODE_DOWN: begin
                is_prbs = 1'b0;
                period  = `PER_CODE_DOWN;
                seed    = `SEED_CODE_DOWN;
            end
            default:        is_prbs = 1'b1;
        endcase
    end

    // Command decode with conflict checks, one loop, code or pattern start per write, plus monitor start
    always @* begin
        wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                 {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
        cmd = (wr_go && aw_addr_reg == `OFF_CMD) ? (w_data_reg & wmask) : 32'h0000_0000;
        refuse_ev = 1'b0;
        start_ev  = 1'b0;
        gen_load  = 1'b0;
        mon_load  = cmd[`CMD_MON_START] && !mon_reg;
        if (cmd[`CMD_LINE] && !line_reg) begin
            refuse_ev = framed_reg || pat_send_reg || code_reg || port_busy;
            start_ev  = !refuse_ev;
        end else if (cmd[`CMD_FRAMED] && !framed_reg) begin
            refuse_ev = line_reg || tsr_reg || pat_send_reg || code_reg
                        || port_busy;
            start_ev  = !refuse_ev;
        end else if (cmd[`CMD_TSR] && !tsr_reg) begin
            refuse_ev = linked_if_loop || framed_reg || pat_send_reg || code_reg
                        || port_busy;
            start_ev  = !refuse_ev;
        end else if ((cmd[`CMD_CODE_UP] || cmd[`CMD_CODE_DOWN]) && !code_reg) begin
            refuse_ev = loop_any || pat_send_reg || port_busy;
            start_ev  = !refuse_ev;
            gen_load  = !refuse_ev;
        end else if ((cmd[`CMD_CODE_UP] || cmd[`CMD_CODE_DOWN]) && code_reg) begin
            refuse_ev = 1'b1;
        end else if (cmd[`CMD_PAT_SEND] && !pat_send_reg) begin
            refuse_ev = loop_any || code_reg || port_busy;
            start_ev  = !refuse_ev;
            gen_load  = !refuse_ev;
        end
        start_ev = start_ev || mon_load;
        code_done_ev = code_reg && (code_cnt_reg == CODE_CYCLES - 32'h0000_0001);
    end

    // Test state
    always @(posedge aclk) begin
        if (!aresetn) begin
            line_reg      <= 1'b0;
            framed_reg    <= 1'b0;
            tsr_reg       <= 1'b0;
            code_reg      <= 1'b0;
            code_down_reg <= 1'b0;
            pat_send_reg  <= 1'b0;
            mon_reg       <= 1'b0;
            refused_reg   <= 1'b0;
            code_cnt_reg  <= 32'h0000_0000;
            sec_cnt_reg   <= 32'h0000_0000;
            elapsed_reg   <= 32'h0000_0000;
        end else begin
            if (cmd[`CMD_STOP_LOOP]) begin
                line_reg   <= 1'b0;
                framed_reg <= 1'b0;
                tsr_reg    <= 1'b0;
            end else if (start_ev && !refuse_ev) begin
                line_reg   <= line_reg   || cmd[`CMD_LINE];
                framed_reg <= framed_reg || (cmd[`CMD_FRAMED] && !cmd[`CMD_LINE]);
                tsr_reg    <= tsr_reg    || (cmd[`CMD_TSR] && !cmd[`CMD_FRAMED]
                                             && !(cmd[`CMD_LINE] && !line_reg));
            end
            if (refuse_ev || start_ev) begin
                refused_reg <= refuse_ev;
            end
            if (gen_load && (cmd[`CMD_CODE_UP] || cmd[`CMD_CODE_DOWN])) begin
                code_reg      <= 1'b1;
                code_down_reg <= cmd[`CMD_CODE_DOWN] && !cmd[`CMD_CODE_UP];
                code_cnt_reg  <= 32'h0000_0000;
            end else if (code_done_ev) begin
                code_reg      <= 1'b0;
            end else if (code_reg) begin
                code_cnt_reg  <= code_cnt_reg + 32'h0000_0001;
            end
            if (gen_load && !code_reg && !cmd[`CMD_CODE_UP] && !cmd[`CMD_CODE_DOWN]) begin
                pat_send_reg <= 1'b1;
            end else if (cmd[`CMD_PAT_STOP]) begin
                pat_send_reg <= 1'b0;
            end
            if (mon_load) begin
                mon_reg <= 1'b1;
            end else if (cmd[`CMD_MON_STOP]) begin
                mon_reg <= 1'b0;
            end
            if (start_ev) begin
                sec_cnt_reg <= 32'h0000_0000;
                elapsed_reg <= 32'h0000_0000;
            end else if (loop_any || pat_send_reg || mon_reg || code_reg) begin
                if (sec_cnt_reg == SEC_CYCLES - 32'h0000_0001) begin
                    sec_cnt_reg <= 32'h0000_0000;
                    elapsed_reg <= elapsed_reg + 32'h0000_0001;
                end else begin
                    sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
                end
            end
        end
    end

    // Datapath selection
    assign tx_raw = framed_reg ? reframed_bit : framer_tx_bit;
    always @(posedge aclk) begin
        if (!aresetn) begin
            line_tx_bit      <= 1'b0;
            rx_to_framer_bit <= 1'b0;
            framed_loop_en   <= 1'b0;
            net_msg_ignore   <= 1'b0;
        end else begin
            framed_loop_en <= framed_reg;
            net_msg_ignore <= tsr_reg;
            if (line_reg) begin
                line_tx_bit <= line_rx_bit;
            end else if (slot_over) begin
                line_tx_bit <= gen_bit;
            end else begin
                line_tx_bit <= tx_raw;
            end
            rx_to_framer_bit <= tsr_reg ? line_tx_bit : line_rx_bit;
        end
    end

    pattern_source u_source (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (gen_load),
        .step    (gen_step),
        .inject  (cmd[`CMD_INJECT] && pat_send_reg),
        .is_prbs (is_prbs),
        .tap_a   (tap_a),
        .tap_b   (tap_b),
        .period  (period),
        .seed    (seed),
        .bit_out (gen_bit)
    );

    pattern_checker u_checker (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .restart   (mon_load),
        .step      (mon_step),
        .bit_in    (rx_to_framer_bit),
        .clear_err (cmd[`CMD_CLR_ERR]),
        .is_prbs   (is_prbs),
        .tap_a     (tap_a),
        .tap_b     (tap_b),
        .period    (period),
        .err_count (err_count),
        .err_pulse (err_pulse),
        .synced    (mon_synced)
    );

    // Read mux
    always @* begin
        rd_ok = 1'b1;
        case (araddr)
            `OFF_CMD:      rd_next = 32'h0000_0000;
            `OFF_STATUS:   rd_next = {23'h00_0000, refused_reg, mon_synced, mon_reg,
                                      pat_send_reg, code_down_reg, code_reg,
                                      tsr_reg, framed_reg, line_reg};
            `OFF_PAT_SEL:  rd_next = {28'h000_0000, pat_sel_reg};
            `OFF_USER_PAT: rd_next = {16'h0000, user_pat_reg};
            `OFF_ELAPSED:  rd_next = elapsed_reg;
            `OFF_ERR_CNT:  rd_next = {16'h0000, err_count};
            `OFF_IRQ_STAT: rd_next = {29'h0000_0000, irq_stat_reg};
            `OFF_IRQ_EN:   rd_next = {29'h0000_0000, irq_en_reg};
            `OFF_IRQ_CLR:  rd_next = 32'h0000_0000;
            default:       begin rd_next = 32'h0000_0000; rd_ok = 1'b0; end
        endcase
    end

    // AXI4-Lite slave and writable registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready      <= 1'b1;
            wready       <= 1'b1;
            bvalid       <= 1'b0;
            bresp        <= `RESP_OKAY;
            arready      <= 1'b1;
            rvalid       <= 1'b0;
            rresp        <= `RESP_OKAY;
            rdata        <= 32'h0000_0000;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            pat_sel_reg  <= `PAT_QRSS;
            user_pat_reg <= 16'h0000;
            irq_en_reg   <= {`IRQ_W{1'b0}};
            irq_stat_reg <= {`IRQ_W{1'b0}};
            irq          <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_addr_reg <= awaddr;
                awready     <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready     <= 1'b0;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= (aw_addr_reg > `OFF_IRQ_CLR || aw_addr_reg[1:0] != 2'b00)
                          ? `RESP_SLVERR : `RESP_OKAY;
                case (aw_addr_reg)
                    `OFF_PAT_SEL:  if (!pat_send_reg && !mon_reg)
                                       pat_sel_reg <= (w_data_reg[3:0] & wmask[3:0]) |
                                                      (pat_sel_reg & ~wmask[3:0]);
                    `OFF_USER_PAT: user_pat_reg <= (w_data_reg[15:0] & wmask[15:0]) |
                                                   (user_pat_reg & ~wmask[15:0]);
                    `OFF_IRQ_EN:   irq_en_reg <= (w_data_reg[`IRQ_W-1:0] & wmask[`IRQ_W-1:0]) |
                                                 (irq_en_reg & ~wmask[`IRQ_W-1:0]);
                    default:       ;
                endcase
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_next;
                rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
            irq_stat_reg <= (irq_stat_reg & ~((wr_go && aw_addr_reg == `OFF_IRQ_CLR)
                            ? (w_data_reg[`IRQ_W-1:0] & wmask[`IRQ_W-1:0])
                            : {`IRQ_W{1'b0}}))
                            | {err_pulse, code_done_ev, refuse_ev};
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end
endmodule // t1_loopback_test_control
`default_nettype wire

// File: testbench/t1_far_end.sv
// Far-end T1 model: bit timing, line traffic, remote line loop.
// Assumes one strobe every four clocks and payload in every bit.
`timescale 1ns/1ps
`default_nettype none
module t1_far_end (
    // Clock and line
    input  wire logic aclk,
    output var  logic bit_strobe,
    output var  logic line_rx_bit,
    input  wire logic line_tx_bit,
    // Remote loop state
    output var  logic looped
);
    logic [1:0] phase = 2'h0;
    logic [9:0] seen  = 10'h3FF;
    initial {bit_strobe, line_rx_bit, looped} = 3'b000;
    always @(posedge aclk) begin
        phase <= phase + 2'h1;
        bit_strobe <= (phase == 2'h3);
        if (phase == 2'h2) begin
            seen <= {seen[8:0], line_tx_bit};
            line_rx_bit <= looped ? line_tx_bit : ~line_rx_bit;
        end
        if (seen == 10'h021) looped <= 1'b1;
        if (seen[8:0] == 9'h049) looped <= 1'b0;
    end
endmodule // t1_far_end
`default_nettype wire

// File: testbench/t1_loop_checker.sv
// Port checker for the T1 test control block.
// Assumes a bind onto the top module.
`timescale 1ns/1ps
`default_nettype none
module t1_loop_checker (
    // Bus
    input wire logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready,
    // Line and framer
    input wire logic line_rx_bit, line_tx_bit, reframed_bit, payload_slot,
    input wire logic rx_to_framer_bit, framed_loop_en, net_msg_ignore
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
    sequence tsr_on; net_msg_ignore ##1 net_msg_ignore; endsequence
    sequence tsr_off; !net_msg_ignore ##1 !net_msg_ignore; endsequence
    AST_WR_ANSWER: assert property (wr_taken |-> ##2 bvalid) else $error("no write reply");
    AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid && !arready) else $error("rd");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid) else $error("bvalid drop");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid) else $error("rvalid drop");
    AST_LOOP_EXCL: assert property (!(framed_loop_en && net_msg_ignore))
        else $error("two loops");
    AST_TSR_RX: assert property (tsr_on |-> rx_to_framer_bit == $past(line_tx_bit))
        else $error("tsr path");
    AST_NORM_RX: assert property (tsr_off |-> rx_to_framer_bit == $past(line_rx_bit))
        else $error("rx path");
    AST_FRAMED: assert property (framed_loop_en && !payload_slot ##1 framed_loop_en
        |-> line_tx_bit == $past(reframed_bit)) else $error("framed path");
endmodule // t1_loop_checker
bind t1_loopback_test_control t1_loop_checker u_chk (.*);
`default_nettype wire

// File: testbench/t1_loopback_test_control_tb.sv
// Bench: loop conflicts, line loop, remote codes, interrupt.
// Assumes the far-end model and bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "t1_loop_consts.vh"
module t1_loopback_test_control_tb;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, payload_slot = 0, framer_tx_bit = 0, reframed_bit = 0, b;
    logic        awready, wready, bvalid, arready, rvalid, irq, bit_strobe, line_rx_bit;
    logic        line_tx_bit, rx_to_framer_bit, framed_loop_en, net_msg_ignore, looped;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  ports = 0;
    int          failures = 0, comparisons = 0, n, k;
    // Port tests, command bit, expected status
    logic [16:0] rows [9] = '{{4'h0, 4'h0, 9'h001}, {4'h1, 4'h0, 9'h100}, {4'h2, 4'h1, 9'h100},
        {4'h4, 4'h2, 9'h100}, {4'h8, 4'h2, 9'h100}, {4'h8, 4'h0, 9'h001},
        {4'h0, 4'h2, 9'h004}, {4'h0, 4'h1, 9'h002}, {4'h4, 4'h4, 9'h100}};
    t1_loopback_test_control #(.SEC_CYCLES(10), .CODE_CYCLES(100)) u_t1_loopback_test_control (
        .wstrb(4'hF), .port_pattern_send(ports[0]), .port_v54_ft1_send(ports[1]),
        .port_data_loop(ports[2]), .linked_if_loop(ports[3]), .*);
    t1_far_end u_t1_far_end (.*);
    always #10 aclk = ~aclk;
    always @(posedge aclk) reframed_bit <= ~reframed_bit ^ line_rx_bit;
    always @(posedge aclk) framer_tx_bit <= line_rx_bit;
    task complete_run;
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [35:0] s, input logic [35:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tmo(input int c);
        if (c >= 50) begin
            failures++;
            complete_run();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
        bready <= 0;
        tmo(n);
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        {d, r} = {rdata, rresp};
        rready <= 0;
        tmo(n);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        #1 check("reset", {bvalid, rvalid, irq, framed_loop_en, net_msg_ignore}, 0);
        foreach (rows[i]) begin
            ports <= rows[i][16:13];
            wr(`OFF_CMD, 32'h1 << rows[i][12:9]);
            rd(`OFF_STATUS);
            check("status", d[8:0], rows[i][8:0]);
            if (rows[i][0]) begin
                @(posedge aclk);
                b = line_rx_bit;
                #1 check("line loop", line_tx_bit, b);
            end
            wr(`OFF_CMD, 32'h1 << `CMD_STOP_LOOP);
        end
        ports <= 0;
        payload_slot <= 1;
        wr(`OFF_IRQ_CLR, 32'h7);
        wr(`OFF_IRQ_EN, 32'h2);
        wr(`OFF_CMD, 32'h1 << `CMD_CODE_UP);
        repeat (60) @(posedge aclk);
        check("far loop", looped, 1);
        rd(`OFF_STATUS);
        check("code on", d[4:3], 2'b01);
        for (k = 0; k < 50 && d[3]; k++) rd(`OFF_STATUS);
        tmo(k);
        #1 check("irq", irq, 1);
        wr(`OFF_IRQ_EN, 0);
        @(posedge aclk);
        #1 check("masked", irq, 0);
        rd(`OFF_IRQ_STAT);
        check("sticky", d[2:0], 3'b010);
        wr(`OFF_IRQ_CLR, 32'h2);
        rd(`OFF_IRQ_STAT);
        check("cleared", d[2:0], 0);
        wr(`OFF_USER_PAT, 32'h0000_FF00);
        wr(`OFF_PAT_SEL, `PAT_USER);
        wr(`OFF_CMD, (32'h1 << `CMD_PAT_SEND) | (32'h1 << `CMD_MON_START));
        repeat (160) @(posedge aclk);
        rd(`OFF_STATUS);
        check("pattern on", d[7:5], 3'b111);
        rd(`OFF_ERR_CNT);
        check("no errors", d, 0);
        wr(`OFF_CMD, 32'h1 << `CMD_INJECT);
        repeat (120) @(posedge aclk);
        rd(`OFF_ERR_CNT);
        check("injected", d, 2);
        rd(`OFF_ELAPSED);
        check("elapsed", d != 0, 1);
        wr(`OFF_CMD, 32'h1 << `CMD_CLR_ERR);
        rd(`OFF_ERR_CNT);
        check("err cleared", d, 0);
        wr(`OFF_CMD, (32'h1 << `CMD_PAT_STOP) | (32'h1 << `CMD_MON_STOP));
        wr(`OFF_CMD, 32'h1 << `CMD_CODE_DOWN);
        repeat (60) @(posedge aclk);
        check("far release", looped, 0);
        rd(8'h24);
        check("unmapped", {r, d}, {`RESP_SLVERR, 32'h0});
        wr(8'h24, 32'h0);
        check("wr unmapped", r, `RESP_SLVERR);
        complete_run();
    end
endmodule // t1_loopback_test_control_tb
`default_nettype wire
